// ---- test/rtc_strobe_gateway_tb_top.sv ----
// Self-checking testbench for the strobe pin mux and command key gateway.
`timescale 1ns/1ns
module rtc_strobe_gateway_tb_top
    import rtc_gate_pkg::*;
;
    logic              clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid, flush;
    logic [5:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata, rdata_bare, bare_seen;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, ptr;
    logic [15:0]       c_lo, c_mid, c_hi, s_lo, s_mid, s_hi;
    logic [7:0]        gpio;
    logic [8:0]        smp;
    logic [3:0]        st_in, st_out;
    int                num_errors, samples_checked, flush_cnt;

    rtc_strobe_gateway #(.HAS_PIN_MUX(1'b1)) uut (
        .clk_i(clk), .arst_n_i(arst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .count_low_word_i(c_lo), .count_mid_word_i(c_mid), .count_high_word_i(c_hi), .gpio_pins_i(gpio),
        .strobe_ch1_i(st_in[0]), .strobe_ch2_i(st_in[1]), .strobe_ch3_i(st_in[2]), .strobe_ch4_i(st_in[3]),
        .sampled_inputs_o(smp), .strobe_out_ch1_o(st_out[0]), .strobe_out_ch2_o(st_out[1]),
        .strobe_out_ch3_o(st_out[2]), .strobe_out_ch4_o(st_out[3]), .flush_posted_o(flush),
        .captured_low_word_o(s_lo), .captured_mid_word_o(s_mid), .captured_high_word_o(s_hi),
        .frozen_read_pointer_o(ptr)
    );

    // Instance without pin muxing; only its read data is watched.
    rtc_strobe_gateway #(.HAS_PIN_MUX(1'b0)) uut_bare (
        .clk_i(clk), .arst_n_i(arst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(),
        .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(),
        .s_axi_rdata_o(rdata_bare), .s_axi_rresp_o(), .s_axi_rvalid_o(), .s_axi_rready_i(rready),
        .count_low_word_i(c_lo), .count_mid_word_i(c_mid), .count_high_word_i(c_hi), .gpio_pins_i(gpio),
        .strobe_ch1_i(st_in[0]), .strobe_ch2_i(st_in[1]), .strobe_ch3_i(st_in[2]), .strobe_ch4_i(st_in[3]),
        .sampled_inputs_o(), .strobe_out_ch1_o(), .strobe_out_ch2_o(),
        .strobe_out_ch3_o(), .strobe_out_ch4_o(), .flush_posted_o(),
        .captured_low_word_o(), .captured_mid_word_o(), .captured_high_word_o(),
        .frozen_read_pointer_o()
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Counts flush pulses so that a pulse longer than one cycle is seen.
    always @(posedge clk)
        if (flush === 1'b1)
            flush_cnt++;

    task automatic conclude();
        $display("Comparisons: %0d, mismatches: %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic hang(input string name);
        num_errors++;
        $display("[FAIL] %s expected answer seen none", name);
        conclude();
    endtask : hang

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) hang("write response");
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        bare_seen = rdata_bare;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50) hang("read data");
        @(posedge clk);
    endtask : rd

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(name, exp, d);
        chk({name, " resp"}, {30'h0, er}, {30'h0, r});
    endtask : rd_chk

    task automatic test_regs();
        logic [1:0] r;
        rd_chk("mux_a reset", 6'h00, 32'h0, RESP_OKAY);
        rd_chk("mux_b reset", 6'h04, 32'h0, RESP_OKAY);
        wr(6'h00, 32'hFFFFFFFF, 4'hF, r);
        chk("mux_a bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        rd_chk("mux_a fields", 6'h00, 32'h00007FFF, RESP_OKAY);
        chk("reserved mux_a", 32'h0, bare_seen);
        wr(6'h04, 32'hFFFFFFFF, 4'hF, r);
        rd_chk("mux_b fields", 6'h04, 32'h0000CFFF, RESP_OKAY);
        chk("reserved mux_b", 32'h0, bare_seen);
        wr(6'h00, 32'h00001234, 4'h1, r);
        rd_chk("mux_a low lane", 6'h00, 32'h00007F34, RESP_OKAY);
        wr(6'h08, 32'h00005555, 4'hF, r);
        rd_chk("gateway read", 6'h08, 32'h0, RESP_OKAY);
        rd_chk("unmapped read", 6'h20, 32'h0, RESP_SLVERR);
        wr(6'h3C, 32'h0000FFFF, 4'hF, r);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask : test_regs

    task automatic test_pins();
        logic [2:0]  s[9];
        logic [1:0]  r;
        logic [7:0]  pat[2];
        logic [8:0]  e;
        pat[0] = 8'hA5;
        pat[1] = 8'h3C;
        for (int i = 0; i < 9; i++) s[i] = 3'((i * 3 + 1) % 8);
        // Strobe inputs stay low, so channels are idle while fields change.
        wr(6'h00, {17'h0, s[4], s[3], s[2], s[1], s[0]}, 4'hF, r);
        wr(6'h04, {20'h0, s[8], s[7], s[6], s[5]}, 4'hF, r);
        for (int p = 0; p < 2; p++)
        begin
            gpio <= pat[p];
            repeat (4) @(posedge clk);
            for (int i = 0; i < 9; i++) e[i] = pat[p][s[i]];
            chk("sampled inputs", {23'h0, e}, {23'h0, smp});
        end
    endtask : test_pins

    task automatic test_diff();
        logic [1:0] r;
        logic [3:0] e;
        for (int d = 0; d < 4; d++)
        begin
            wr(6'h04, {16'h0, d[1], d[0], 14'h0}, 4'hF, r);
            for (int v = 0; v < 16; v++)
            begin
                st_in <= 4'(v);
                repeat (2) @(posedge clk);
                e[0] = v[0];
                e[1] = d[0] ? ~v[0] : v[1];
                e[2] = v[2];
                e[3] = d[1] ? ~v[2] : v[3];
                chk("strobe outputs", {28'h0, e}, {28'h0, st_out});
            end
        end
        st_in <= 4'h0;
    endtask : test_diff

    task automatic test_keys();
        logic [1:0] r;
        int         f0;
        c_lo <= 16'h1111;
        c_mid <= 16'h2222;
        c_hi <= 16'h3333;
        wr(6'h08, {16'h0, KEY_SNAPSHOT}, 4'hF, r);
        chk("snapshot low mid", 32'h22221111, {s_mid, s_lo});
        chk("snapshot high", 32'h3333, {16'h0, s_hi});
        c_lo <= 16'h4444;
        c_mid <= 16'h5555;
        c_hi <= 16'h6666;
        rd_chk("snap low", 6'h0C, 32'h1111, RESP_OKAY);
        rd_chk("snap mid", 6'h10, 32'h2222, RESP_OKAY);
        rd_chk("snap high", 6'h14, 32'h3333, RESP_OKAY);
        rd_chk("frozen first", 6'h18, 32'h4444, RESP_OKAY);
        c_lo <= 16'h7777;
        c_mid <= 16'h8888;
        c_hi <= 16'h9999;
        rd_chk("frozen second", 6'h18, 32'h5555, RESP_OKAY);
        rd_chk("frozen third", 6'h18, 32'h6666, RESP_OKAY);
        rd_chk("frozen wrap", 6'h18, 32'h7777, RESP_OKAY);
        chk("pointer", 32'h1, {30'h0, ptr});
        f0 = flush_cnt;
        wr(6'h08, 32'h00001234, 4'hF, r);
        chk("idle key pointer", 32'h1, {30'h0, ptr});
        chk("idle key snapshot", 32'h22221111, {s_mid, s_lo});
        chk("idle key snapshot high", 32'h3333, {16'h0, s_hi});
        chk("idle key flush", 32'(f0), 32'(flush_cnt));
        wr(6'h08, {16'h0, KEY_PTR_CLEAR}, 4'hF, r);
        chk("cleared pointer", 32'h0, {30'h0, ptr});
        rd_chk("status", 6'h1C, 32'h0, RESP_OKAY);
        rd_chk("restart first", 6'h18, 32'h7777, RESP_OKAY);
        wr(6'h08, {16'h0, KEY_FLUSH}, 4'hF, r);
        repeat (2) @(posedge clk);
        chk("flush pulses", 32'(f0 + 1), 32'(flush_cnt));
    endtask : test_keys

    initial
    begin
        arst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        {c_lo, c_mid, c_hi} = '0;
        gpio = 8'h00;
        st_in = 4'h0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        test_regs();
        test_pins();
        test_diff();
        test_keys();
        conclude();
    end
endmodule : rtc_strobe_gateway_tb_top

// ---- verilog/rtc_gate_pkg.sv ----
// Constants for the strobe pin mux and command key gateway block.
package rtc_gate_pkg;

    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 32;
    localparam int          WORD_W          = 16;
    localparam int          PIN_CNT         = 8;
    localparam int          SEL_CNT         = 9;

    // Word indices of the register map; byte address is four times the index.
    localparam logic [3:0]  IDX_MUX_A       = 4'h0;
    localparam logic [3:0]  IDX_MUX_B       = 4'h1;
    localparam logic [3:0]  IDX_GATEWAY     = 4'h2;
    localparam logic [3:0]  IDX_SNAP_LOW    = 4'h3;
    localparam logic [3:0]  IDX_SNAP_MID    = 4'h4;
    localparam logic [3:0]  IDX_SNAP_HIGH   = 4'h5;
    localparam logic [3:0]  IDX_FROZEN      = 4'h6;
    localparam logic [3:0]  IDX_STATUS      = 4'h7;
    localparam logic [3:0]  IDX_LAST        = 4'h7;

    // Field positions of the pin select fields, LSB of each 3-bit field, then the two differential mode bits.
    localparam int          CH1_IN0_LSB     = 0;
    localparam int          CH1_IN1_LSB     = 3;
    localparam int          CH1_IN2_LSB     = 6;
    localparam int          CH2_IN0_LSB     = 9;
    localparam int          CH2_IN1_LSB     = 12;
    localparam int          CH2_IN2_LSB     = 0;
    localparam int          CH3_IN0_LSB     = 3;
    localparam int          CH3_IN1_LSB     = 6;
    localparam int          CH3_IN2_LSB     = 9;
    localparam int          CH1_DIFF_BIT    = 14;
    localparam int          CH3_DIFF_BIT    = 15;

    localparam logic [15:0] MUX_A_MASK      = 16'h7FFF;
    localparam logic [15:0] MUX_B_MASK      = 16'hCFFF;
    localparam logic [15:0] MUX_RESET       = 16'h0000;
    localparam logic [15:0] WORD_RESET      = 16'h0000;

    localparam logic [15:0] KEY_FLUSH       = 16'hA2C5;
    localparam logic [15:0] KEY_SNAPSHOT    = 16'h7627;
    localparam logic [15:0] KEY_PTR_CLEAR   = 16'h9376;

    localparam logic [1:0]  PTR_FIRST       = 2'h0;
    localparam logic [1:0]  PTR_SECOND      = 2'h1;
    localparam logic [1:0]  PTR_THIRD       = 2'h2;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : rtc_gate_pkg

// ---- verilog/rtc_strobe_gateway.sv ----
// Strobe pin mux registers, differential strobe outputs and command key gateway.
//
// Function
// [R1] Channel 1 inputs 0, 1 and 2 sample the pin chosen by bits 2:0, 5:3 and 8:6 of the first mux register.
// [R2] Channel 2 inputs 0 and 1 use bits 11:9 and 14:12 of the first mux register, input 2 bits 2:0 of the second.
// [R3] Channel 3 inputs 0, 1 and 2 use bits 5:3, 8:6 and 11:9 of the second mux register.
// [R4] Software changes a pin select field only while the channel using it is disabled.
// [R5] Without pin muxing both mux addresses are reserved and read back their reset value.
// [R6] Bit 15 of the second mux register makes the channel 4 strobe the inverse of channel 3.
// [R7] Bit 14 of the second mux register makes the channel 2 strobe the inverse of channel 1.
// [R8] The gateway register always reads as zero.
// [R9] Key 0xA2C5 flushes all posted writes and aborts the one in progress; the code only pulses flush_posted_o for one cycle.
// [R10] Key 0x7627 captures the low, middle and high count words together and holds them.
// [R11] Key 0x9376 clears the frozen read pointer so the next frozen read starts a new triple.
// [R12] The first frozen read returns the live low word and freezes middle and high for the next two reads.
// [R13] A gateway write matching no key has no effect.
`timescale 1ns/1ns
module rtc_strobe_gateway
    import rtc_gate_pkg::*;
#(
    parameter bit HAS_PIN_MUX = 1'b1
)(
    input  wire logic                clk_i,
    input  wire logic                arst_n_i,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr_i,
    input  wire logic                s_axi_awvalid_i,
    output logic                     s_axi_awready_o,
    input  wire logic [DATA_W-1:0]   s_axi_wdata_i,
    input  wire logic [3:0]          s_axi_wstrb_i,
    input  wire logic                s_axi_wvalid_i,
    output logic                     s_axi_wready_o,
    output logic [1:0]               s_axi_bresp_o,
    output logic                     s_axi_bvalid_o,
    input  wire logic                s_axi_bready_i,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr_i,
    input  wire logic                s_axi_arvalid_i,
    output logic                     s_axi_arready_o,
    output logic [DATA_W-1:0]        s_axi_rdata_o,
    output logic [1:0]               s_axi_rresp_o,
    output logic                     s_axi_rvalid_o,
    input  wire logic                s_axi_rready_i,
    input  wire logic [WORD_W-1:0]   count_low_word_i,
    input  wire logic [WORD_W-1:0]   count_mid_word_i,
    input  wire logic [WORD_W-1:0]   count_high_word_i,
    input  wire logic [PIN_CNT-1:0]  gpio_pins_i,
    input  wire logic                strobe_ch1_i,
    input  wire logic                strobe_ch2_i,
    input  wire logic                strobe_ch3_i,
    input  wire logic                strobe_ch4_i,
    output logic [SEL_CNT-1:0]       sampled_inputs_o,
    output logic                     strobe_out_ch1_o,
    output logic                     strobe_out_ch2_o,
    output logic                     strobe_out_ch3_o,
    output logic                     strobe_out_ch4_o,
    output logic                     flush_posted_o,
    output logic [WORD_W-1:0]        captured_low_word_o,
    output logic [WORD_W-1:0]        captured_mid_word_o,
    output logic [WORD_W-1:0]        captured_high_word_o,
    output logic [1:0]               frozen_read_pointer_o
);

    function automatic logic [3:0] word_of(input logic [ADDR_W-1:0] addr);
        word_of = addr[5:2];
    endfunction : word_of

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
        merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction : merge

    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic [15:0]       strobe_pin_select_a;
    logic [15:0]       strobe_pin_select_b;
    logic [15:0]       frozen_mid;
    logic [15:0]       frozen_high;
    logic [PIN_CNT-1:0] pin_meta;
    logic [PIN_CNT-1:0] pin_sync;
    logic [3:0]        rd_idx;

    // Write channel handshakes and the write commit point.
    wire               aw_fire      = s_axi_awvalid_i & s_axi_awready_o;
    wire               w_fire       = s_axi_wvalid_i & s_axi_wready_o;
    wire               do_write     = aw_held & w_held & ~s_axi_bvalid_o;
    wire [3:0]         wr_idx       = word_of(aw_addr);
    wire               wr_mapped    = wr_idx <= IDX_LAST;
    wire               next_aw_held = aw_fire | (aw_held & ~do_write);
    wire               next_w_held  = w_fire | (w_held & ~do_write);
    wire               next_bvalid  = do_write | (s_axi_bvalid_o & ~s_axi_bready_i);

    // Read channel handshake.
    wire               ar_fire      = s_axi_arvalid_i & s_axi_arready_o;
    wire [3:0]         ar_idx       = word_of(s_axi_araddr_i);
    wire               ar_mapped    = ar_idx <= IDX_LAST;
    wire               next_rvalid  = ar_fire | (s_axi_rvalid_o & ~s_axi_rready_i);

    // Gateway key decode; a key needs both low byte lanes.
    // [R13] Unknown keys inert.
    wire               gw_write     = do_write & (wr_idx == IDX_GATEWAY) & (w_strb[1:0] == 2'b11);
    wire               key_flush    = gw_write & (w_data[15:0] == KEY_FLUSH);
    wire               key_snap     = gw_write & (w_data[15:0] == KEY_SNAPSHOT);
    wire               key_clear    = gw_write & (w_data[15:0] == KEY_PTR_CLEAR);

    // Frozen count port access and pointer advance.
    wire               frz_read     = ar_fire & (ar_idx == IDX_FROZEN);
    wire               frz_first    = frz_read & (frozen_read_pointer_o == PTR_FIRST);
    wire [1:0]         ptr_step     = (frozen_read_pointer_o == PTR_THIRD) ? PTR_FIRST
                                                                           : frozen_read_pointer_o + 2'h1;
    // [R11] Clear key wins.
    wire [1:0]         next_ptr     = key_clear ? PTR_FIRST : (frz_read ? ptr_step : frozen_read_pointer_o);
    // [R12] Frozen word select.
    wire [15:0]        frz_word     = (frozen_read_pointer_o == PTR_FIRST)  ? count_low_word_i :
                                      (frozen_read_pointer_o == PTR_SECOND) ? frozen_mid : frozen_high;

    wire [15:0]        mux_a_eff    = HAS_PIN_MUX ? strobe_pin_select_a : MUX_RESET;
    wire [15:0]        mux_b_eff    = HAS_PIN_MUX ? strobe_pin_select_b : MUX_RESET;
    wire               ch1_diff     = mux_b_eff[CH1_DIFF_BIT];
    wire               ch3_diff     = mux_b_eff[CH3_DIFF_BIT];

    // [R8] Gateway reads as zero.
    wire [15:0]        rd_word      = (ar_idx == IDX_MUX_A)     ? mux_a_eff :
                                      (ar_idx == IDX_MUX_B)     ? mux_b_eff :
                                      (ar_idx == IDX_GATEWAY)   ? WORD_RESET :
                                      (ar_idx == IDX_SNAP_LOW)  ? captured_low_word_o :
                                      (ar_idx == IDX_SNAP_MID)  ? captured_mid_word_o :
                                      (ar_idx == IDX_SNAP_HIGH) ? captured_high_word_o :
                                      (ar_idx == IDX_FROZEN)    ? frz_word :
                                      (ar_idx == IDX_STATUS)    ? {14'h0000, frozen_read_pointer_o} : WORD_RESET;

    // [R1] Channel 1 select fields.
    // [R2] Channel 2 select fields.
    // [R3] Channel 3 select fields.
    wire [2:0]         pin_sel [SEL_CNT];
    assign pin_sel[0] = mux_a_eff[CH1_IN0_LSB +: 3];
    assign pin_sel[1] = mux_a_eff[CH1_IN1_LSB +: 3];
    assign pin_sel[2] = mux_a_eff[CH1_IN2_LSB +: 3];
    assign pin_sel[3] = mux_a_eff[CH2_IN0_LSB +: 3];
    assign pin_sel[4] = mux_a_eff[CH2_IN1_LSB +: 3];
    assign pin_sel[5] = mux_b_eff[CH2_IN2_LSB +: 3];
    assign pin_sel[6] = mux_b_eff[CH3_IN0_LSB +: 3];
    assign pin_sel[7] = mux_b_eff[CH3_IN1_LSB +: 3];
    assign pin_sel[8] = mux_b_eff[CH3_IN2_LSB +: 3];

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= gpio_pins_i;
            pin_sync <= pin_meta;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SEL_CNT; gi++)
        begin : g_sample
            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                    sampled_inputs_o[gi] <= 1'b0;
                else
                    sampled_inputs_o[gi] <= pin_sync[pin_sel[gi]];
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            strobe_out_ch1_o <= 1'b0;
            strobe_out_ch2_o <= 1'b0;
            strobe_out_ch3_o <= 1'b0;
            strobe_out_ch4_o <= 1'b0;
        end
        else
        begin
            strobe_out_ch1_o <= strobe_ch1_i;
            // [R7] Channel 2 inverts channel 1.
            strobe_out_ch2_o <= ch1_diff ? ~strobe_ch1_i : strobe_ch2_i;
            strobe_out_ch3_o <= strobe_ch3_i;
            // [R6] Channel 4 inverts channel 3.
            strobe_out_ch4_o <= ch3_diff ? ~strobe_ch3_i : strobe_ch4_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= '0;
            w_data          <= '0;
            w_strb          <= '0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
        end
        else
        begin
            aw_held         <= next_aw_held;
            w_held          <= next_w_held;
            s_axi_awready_o <= ~next_aw_held & ~next_bvalid;
            s_axi_wready_o  <= ~next_w_held & ~next_bvalid;
            s_axi_bvalid_o  <= next_bvalid;
            if (aw_fire)
                aw_addr <= s_axi_awaddr_i;
            if (w_fire)
            begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write)
                s_axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= RESP_OKAY;
            rd_idx          <= '0;
        end
        else
        begin
            s_axi_arready_o <= ~next_rvalid;
            s_axi_rvalid_o  <= next_rvalid;
            if (ar_fire)
            begin
                s_axi_rdata_o <= {16'h0000, rd_word};
                s_axi_rresp_o <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
                rd_idx        <= ar_idx;
            end
        end
    end

    // Mux registers; in an instance without muxing the writes are dropped.
    // [R5] Reserved mux registers.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            strobe_pin_select_a <= MUX_RESET;
            strobe_pin_select_b <= MUX_RESET;
        end
        else if (do_write && HAS_PIN_MUX)
        begin
            if (wr_idx == IDX_MUX_A)
                strobe_pin_select_a <= merge(strobe_pin_select_a, w_data, w_strb) & MUX_A_MASK;
            if (wr_idx == IDX_MUX_B)
                strobe_pin_select_b <= merge(strobe_pin_select_b, w_data, w_strb) & MUX_B_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flush_posted_o        <= 1'b0;
            captured_low_word_o   <= WORD_RESET;
            captured_mid_word_o   <= WORD_RESET;
            captured_high_word_o  <= WORD_RESET;
            frozen_mid            <= WORD_RESET;
            frozen_high           <= WORD_RESET;
            frozen_read_pointer_o <= PTR_FIRST;
        end
        else
        begin
            // [R9] Flush pulse.
            flush_posted_o        <= key_flush;
            frozen_read_pointer_o <= next_ptr;
            // [R10] Coherent capture.
            if (key_snap)
            begin
                captured_low_word_o  <= count_low_word_i;
                captured_mid_word_o  <= count_mid_word_i;
                captured_high_word_o <= count_high_word_i;
            end
            // [R12] Freeze on first read.
            if (frz_first)
            begin
                frozen_mid  <= count_mid_word_i;
                frozen_high <= count_high_word_i;
            end
        end
    end

    property p_gw_read_zero;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_axi_rvalid_o && rd_idx == IDX_GATEWAY |-> s_axi_rdata_o == '0;
    endproperty
    a_gw_read_zero: assert property (p_gw_read_zero) else $error("gateway read not zero"); // [R8]

    property p_flush;
        @(posedge clk_i) disable iff (!arst_n_i)
        key_flush |=> flush_posted_o ##1 !flush_posted_o || key_flush;
    endproperty
    a_flush: assert property (p_flush) else $error("flush pulse wrong"); // [R9]

    property p_snap;
        @(posedge clk_i) disable iff (!arst_n_i)
        key_snap |=> captured_low_word_o == $past(count_low_word_i)
                  && captured_mid_word_o == $past(count_mid_word_i)
                  && captured_high_word_o == $past(count_high_word_i);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot not captured"); // [R10]

    property p_ptr_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        key_clear |=> frozen_read_pointer_o == PTR_FIRST;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared"); // [R11]

    property p_frz_first;
        @(posedge clk_i) disable iff (!arst_n_i)
        frz_first && !key_clear |=> s_axi_rdata_o[15:0] == $past(count_low_word_i)
                                 && frozen_read_pointer_o == PTR_SECOND;
    endproperty
    a_frz_first: assert property (p_frz_first) else $error("first frozen read wrong"); // [R12]

    property p_diff1;
        @(posedge clk_i) disable iff (!arst_n_i)
        ch1_diff && $stable(strobe_pin_select_b) |=> strobe_out_ch2_o != strobe_out_ch1_o;
    endproperty
    a_diff1: assert property (p_diff1) else $error("ch2 not inverse of ch1"); // [R7]

    property p_diff3;
        @(posedge clk_i) disable iff (!arst_n_i)
        ch3_diff && $stable(strobe_pin_select_b) |=> strobe_out_ch4_o != strobe_out_ch3_o;
    endproperty
    a_diff3: assert property (p_diff3) else $error("ch4 not inverse of ch3"); // [R6]

    property p_no_key;
        @(posedge clk_i) disable iff (!arst_n_i)
        do_write && wr_idx == IDX_GATEWAY && !key_flush && !key_snap && !key_clear && !frz_read
        |=> !flush_posted_o && $stable(captured_low_word_o) && $stable(frozen_read_pointer_o);
    endproperty
    a_no_key: assert property (p_no_key) else $error("unknown key had effect"); // [R13]

    property p_reserved_mux;
        @(posedge clk_i) disable iff (!arst_n_i)
        !HAS_PIN_MUX && s_axi_rvalid_o && (rd_idx == IDX_MUX_A || rd_idx == IDX_MUX_B)
        |-> s_axi_rdata_o == '0;
    endproperty
    a_reserved_mux: assert property (p_reserved_mux) else $error("reserved mux not reset value"); // [R5]

    property p_ch1_in0;
        @(posedge clk_i) disable iff (!arst_n_i)
        $stable(strobe_pin_select_a) |=> sampled_inputs_o[0] == $past(pin_sync[strobe_pin_select_a[2:0]])
                                          || !HAS_PIN_MUX;
    endproperty
    a_ch1_in0: assert property (p_ch1_in0) else $error("ch1 in0 wrong pin"); // [R1]

endmodule : rtc_strobe_gateway
